// [hw/uart_channel.v]
// one uart channel: register bank, fifos, serial engines and interrupt output
`timescale 1ns/1ns
`default_nettype none
`include "uart_regs.vh"
// Notes on behaviour
// (R1) divisor bytes at 0x00/0x01 only when divisor-latch bit set and line control not 0xbf
// (R2) feature control and flow characters visible only when line control equals 0xbf
// (R3) general registers visible only while divisor-latch bit is clear
// (R4) enhanced-only control bits change only when enhanced-functions enable is set
// (R5) host writes zero into all reserved bits
// (R6) host waits two clocks after a fifo clear before data access
// (R7) host avoids burst reads of the interrupt identification register
// (R8) transmission control and trigger level need enhanced enable and modem bit 2
// (R9) gpio registers are one shared copy for both channels
// (R10) feature control: auto cts 7, auto rts 6, special 5, enable 4, flow 3:0
// (R11) receiver shifts rx line into characters pushed into 64-byte receive fifo
// (R12) fifos disabled: receive holds one character in entry zero
// (R13) line control word length and parity steer the receiver, which always takes one stop bit
// (R14) host bytes queue in 64-byte transmit fifo, shifted out on tx
// (R15) fifos disabled: transmit holds one byte in entry zero
// (R16) writes to a full transmit fifo are dropped
// (R17) interrupt output active when any enabled source is pending
// (R18) cts and rts low-to-high changes interrupt via enable bits 7 and 6
// (R19) enable bit 5 gates the received pause-character interrupt
// (R20) enable bit 4 permits sleep
// (R21) enable bit 3 gates the modem status interrupt
// (R22) enable bit 2 gates the receive line status interrupt
// (R23) enable bit 1 gates transmit holding, bit 0 receive data interrupt
// (R24) re-enabling transmit interrupt does not raise a fresh one
// (R25) all interrupt enables reset to zero
module uart_channel (
  // clock and reset
  input wire REF_CLK,
  input wire RESET,
  // register access from the serial host port
  input wire [3:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  output wire [7:0] REG_RDATA,
  // shared gpio register set
  output wire IO_WR,
  output wire IO_RD,
  input wire [7:0] IO_RDATA,
  // line pins
  input wire RX,
  input wire CTS_N,
  output wire TX,
  output wire RTS_N,
  // status
  output wire IRQ_N,
  output wire SLEEP_OK
);
  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_DATA = 3'd2;
  localparam S_PAR = 3'd3;
  localparam S_STOP = 3'd4;

  function [3:0] wlen;
    input [1:0] sel;
    wlen = {2'b01, sel} + 4'd1;
  endfunction
  function par_bit;
    input [7:0] d;
    input [7:0] lc;
    reg [7:0] m;
    begin
      m = d & (8'hff >> (4'd8 - wlen(lc[1:0])));
      if (lc[5]) begin
        par_bit = ~lc[4];
      end else begin
        par_bit = (^m) ^ ~lc[4];
      end
    end
  endfunction

  reg [7:0] div_lo_q, div_hi_q, feat_q, resume1_q, resume2_q, pause1_q, pause2_q;
  reg [7:0] ien_q, lctl_q, mctl_q, scratch_q, flow_lvl_q, trig_lvl_q, rdata_q;
  reg [3:0] fifo_ctl_q;
  reg rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q, cts_prev_q, rts_prev_q;
  reg pe_q, fe_q, oe_q, dcts_q, txh_flag_q, xoff_flag_q, cts_flag_q, rts_flag_q;
  reg [15:0] div_cnt_q;
  reg tick_q;
  reg [2:0] rx_st_q, tx_st_q;
  reg [4:0] rx_cnt_q, tx_cnt_q;
  reg [3:0] rx_idx_q, tx_idx_q;
  reg [7:0] rx_sr_q, tx_sr_q;
  reg rx_perr_q, tx_q, tx_empty_prev_q;
  reg [7:0] rd_mux;

  wire enh_set = (lctl_q == `LCTL_ENHANCED); // R2
  wire div_set = lctl_q[`LCTL_DLAB] && !enh_set; // R1
  wire gen_set = !lctl_q[`LCTL_DLAB]; // R3
  wire enh_en = feat_q[`FEAT_ENH_EN];
  wire lvl_vis = enh_en && mctl_q[`MCTL_LVL_SEL]; // R8
  wire fifo_en = fifo_ctl_q[0];
  wire wr_at_hold = REG_WR && gen_set && (REG_ADDR == `OFS_HOLD);
  wire rd_at_hold = REG_RD && gen_set && (REG_ADDR == `OFS_HOLD);
  wire wr_at_fifo = REG_WR && gen_set && (REG_ADDR == `OFS_FIFO);
  wire rd_at_ident = REG_RD && gen_set && (REG_ADDR == `OFS_FIFO);
  wire rd_at_lstat = REG_RD && gen_set && (REG_ADDR == `OFS_LSTAT);
  wire rd_at_mstat = REG_RD && gen_set && (REG_ADDR == `OFS_MSTAT) && !lvl_vis;
  wire io_sel = gen_set && (REG_ADDR >= `OFS_IO_FIRST) && (REG_ADDR <= `OFS_IO_LAST);
  // a single copy lives outside both channels
  assign IO_WR = REG_WR && io_sel; // R9
  assign IO_RD = REG_RD && io_sel; // R9
  // clear is one cycle here, the host's two-clock wait covers it
  wire rx_clear = wr_at_fifo && REG_WDATA[1]; // R6
  wire tx_clear = wr_at_fifo && REG_WDATA[2]; // R6

  // fifos
  wire rx_push, rx_in_ready, rx_out_valid, tx_in_ready, tx_out_valid, tx_take;
  wire [7:0] rx_push_data, rx_out_data, tx_out_data;
  wire [`FIFO_AW:0] rx_level, tx_level;
  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) rx_fifo (
    .clk(REF_CLK),
    .reset(RESET),
    .clear(rx_clear),
    .single(!fifo_en), // R12
    .in_valid(rx_push), // R11
    .in_ready(rx_in_ready),
    .in_data(rx_push_data),
    .out_valid(rx_out_valid),
    .out_ready(rd_at_hold),
    .out_data(rx_out_data),
    .level(rx_level)
  );
  // a write with in_ready low is simply not taken
  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) tx_fifo (
    .clk(REF_CLK),
    .reset(RESET),
    .clear(tx_clear),
    .single(!fifo_en), // R15
    .in_valid(wr_at_hold), // R14 R16
    .in_ready(tx_in_ready),
    .in_data(REG_WDATA),
    .out_valid(tx_out_valid),
    .out_ready(tx_take),
    .out_data(tx_out_data),
    .level(tx_level)
  );

  // pin synchronisers and baud enable
  wire [15:0] divisor = {div_hi_q, div_lo_q};
  always @(posedge REF_CLK) begin
    if (RESET) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
      cts_prev_q <= 1'b1;
      div_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      rx_s1_q <= RX;
      rx_s2_q <= rx_s1_q;
      cts_s1_q <= CTS_N;
      cts_s2_q <= cts_s1_q;
      cts_prev_q <= cts_s2_q;
      // divisor zero stops the engines
      tick_q <= (divisor != 16'h0000) && (div_cnt_q <= 16'h0001);
      if (div_cnt_q <= 16'h0001) begin
        div_cnt_q <= divisor;
      end else begin
        div_cnt_q <= div_cnt_q - 16'h0001;
      end
    end
  end

  // receiver
  wire [3:0] rx_wl = wlen(lctl_q[1:0]);
  wire rx_bit_end = tick_q && (rx_cnt_q == 5'd15);
  wire rx_done = rx_bit_end && (rx_st_q == S_STOP);
  assign rx_push = rx_done;
  assign rx_push_data = rx_sr_q >> (4'd8 - rx_wl); // R13
  always @(posedge REF_CLK) begin
    if (RESET) begin
      rx_st_q <= S_IDLE;
      rx_cnt_q <= 5'd0;
      rx_idx_q <= 4'd0;
      rx_sr_q <= 8'h00;
      rx_perr_q <= 1'b0;
    end else begin
      if (tick_q && rx_st_q != S_IDLE) begin
        rx_cnt_q <= (rx_cnt_q == 5'd15) ? 5'd0 : rx_cnt_q + 5'd1;
      end
      case (rx_st_q)
        S_IDLE: begin
          rx_cnt_q <= 5'd0;
          if (!rx_s2_q) begin
            rx_st_q <= S_START;
          end
        end
        S_START: begin
          // sample mid start bit, then realign bit boundaries
          if (tick_q && rx_cnt_q == 5'd7) begin
            rx_cnt_q <= 5'd0;
            rx_idx_q <= 4'd0;
            rx_st_q <= rx_s2_q ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_bit_end) begin
            rx_sr_q <= {rx_s2_q, rx_sr_q[7:1]};
            rx_idx_q <= rx_idx_q + 4'd1;
            if (rx_idx_q == rx_wl - 4'd1) begin
              rx_st_q <= lctl_q[3] ? S_PAR : S_STOP; // R13
            end
          end
        end
        S_PAR: begin
          if (rx_bit_end) begin
            rx_perr_q <= rx_s2_q ^ par_bit(rx_push_data, lctl_q); // R13
            rx_st_q <= S_STOP;
          end
        end
        S_STOP: begin
          if (rx_bit_end) begin
            rx_st_q <= S_IDLE;
          end
        end
        default: rx_st_q <= S_IDLE;
      endcase
      if (rx_st_q == S_START) begin
        rx_perr_q <= 1'b0;
      end
    end
  end

  // transmitter
  wire [3:0] tx_wl = wlen(lctl_q[1:0]);
  wire cts_ok = !feat_q[`FEAT_AUTO_CTS] || !cts_s2_q;
  assign tx_take = (tx_st_q == S_IDLE) && tx_out_valid && cts_ok && tick_q; // R14
  // stop length 1, 1.5 or 2 bits in sixteenths
  wire [4:0] stop_last = !lctl_q[2] ? 5'd15 : ((lctl_q[1:0] == 2'b00) ? 5'd23 : 5'd31);
  wire [4:0] tx_last = (tx_st_q == S_STOP) ? stop_last : `TICKS_PER_BIT - 5'd1;
  wire tx_bit_end = tick_q && (tx_cnt_q == tx_last);
  always @(posedge REF_CLK) begin
    if (RESET) begin
      tx_st_q <= S_IDLE;
      tx_cnt_q <= 5'd0;
      tx_idx_q <= 4'd0;
      tx_sr_q <= 8'h00;
      tx_q <= 1'b1;
    end else begin
      if (tick_q && tx_st_q != S_IDLE) begin
        tx_cnt_q <= tx_bit_end ? 5'd0 : tx_cnt_q + 5'd1;
      end
      case (tx_st_q)
        S_IDLE: begin
          tx_q <= 1'b1;
          tx_cnt_q <= 5'd0;
          if (tx_take) begin
            tx_sr_q <= tx_out_data;
            tx_q <= 1'b0;
            tx_st_q <= S_START;
          end
        end
        S_START: begin
          if (tx_bit_end) begin
            tx_q <= tx_sr_q[0];
            tx_idx_q <= 4'd0;
            tx_st_q <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_bit_end) begin
            tx_idx_q <= tx_idx_q + 4'd1;
            if (tx_idx_q == tx_wl - 4'd1) begin
              tx_q <= lctl_q[3] ? par_bit(tx_sr_q, lctl_q) : 1'b1;
              tx_st_q <= lctl_q[3] ? S_PAR : S_STOP;
            end else begin
              tx_q <= tx_sr_q[tx_idx_q[2:0] + 3'd1];
            end
          end
        end
        S_PAR: begin
          if (tx_bit_end) begin
            tx_q <= 1'b1;
            tx_st_q <= S_STOP;
          end
        end
        S_STOP: begin
          if (tx_bit_end) begin
            tx_st_q <= S_IDLE;
          end
        end
        default: tx_st_q <= S_IDLE;
      endcase
    end
  end
  assign TX = tx_q && !lctl_q[`LCTL_BREAK];
  assign RTS_N = !mctl_q[`MCTL_RTS];

  // register writes
  always @(posedge REF_CLK) begin
    if (RESET) begin
      div_lo_q <= `RST_DIV_LO;
      div_hi_q <= `RST_DIV_HI;
      feat_q <= 8'h00;
      resume1_q <= 8'h00;
      resume2_q <= 8'h00;
      pause1_q <= 8'h00;
      pause2_q <= 8'h00;
      ien_q <= 8'h00; // R25
      lctl_q <= `RST_LCTL;
      mctl_q <= 8'h00;
      scratch_q <= 8'h00;
      flow_lvl_q <= 8'h00;
      trig_lvl_q <= 8'h00;
      fifo_ctl_q <= 4'h0;
    end else if (REG_WR) begin
      if (REG_ADDR == `OFS_LCTL) begin
        lctl_q <= REG_WDATA;
      end else if (div_set) begin
        if (REG_ADDR == `OFS_HOLD) div_lo_q <= REG_WDATA; // R1
        if (REG_ADDR == `OFS_IEN) div_hi_q <= REG_WDATA; // R1
      end else if (enh_set) begin
        case (REG_ADDR)
          4'h2: feat_q <= REG_WDATA; // R2 R10
          4'h4: resume1_q <= REG_WDATA; // R2
          4'h5: resume2_q <= REG_WDATA;
          4'h6: pause1_q <= REG_WDATA;
          4'h7: pause2_q <= REG_WDATA;
          default: ;
        endcase
      end else begin
        case (REG_ADDR)
          `OFS_IEN: ien_q <= {enh_en ? REG_WDATA[7:4] : ien_q[7:4], REG_WDATA[3:0]}; // R4
          `OFS_FIFO: fifo_ctl_q <= {enh_en ? REG_WDATA[5:4] : fifo_ctl_q[3:2], 1'b0, REG_WDATA[0]}; // R4
          `OFS_MCTL: mctl_q <= {enh_en ? REG_WDATA[7:5] : mctl_q[7:5], REG_WDATA[4:3],
                                enh_en ? REG_WDATA[2] : mctl_q[2], REG_WDATA[1:0]}; // R4
          `OFS_MSTAT: if (lvl_vis) flow_lvl_q <= REG_WDATA; // R8
          `OFS_SCRATCH: begin
            if (lvl_vis) begin
              trig_lvl_q <= REG_WDATA; // R8
            end else begin
              scratch_q <= REG_WDATA;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // sticky event flags: a set in the clearing cycle wins
  wire tx_empty = (tx_level == {(`FIFO_AW+1){1'b0}});
  wire xoff_seen = rx_done && (feat_q[3:0] != 4'h0) && (rx_push_data == pause1_q);
  always @(posedge REF_CLK) begin
    if (RESET) begin
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      oe_q <= 1'b0;
      dcts_q <= 1'b0;
      txh_flag_q <= 1'b0;
      xoff_flag_q <= 1'b0;
      cts_flag_q <= 1'b0;
      rts_flag_q <= 1'b0;
      rts_prev_q <= 1'b1;
      tx_empty_prev_q <= 1'b1;
    end else begin
      rts_prev_q <= RTS_N;
      tx_empty_prev_q <= tx_empty;
      pe_q <= (rx_done && rx_perr_q) || (pe_q && !rd_at_lstat);
      fe_q <= (rx_done && !rx_s2_q) || (fe_q && !rd_at_lstat);
      oe_q <= (rx_done && !rx_in_ready) || (oe_q && !rd_at_lstat);
      dcts_q <= (cts_s2_q != cts_prev_q) || (dcts_q && !rd_at_mstat);
      // only an emptying edge seen while enabled raises it
      txh_flag_q <= (tx_empty && !tx_empty_prev_q && ien_q[`IEN_TXH]) ||
                    (txh_flag_q && !rd_at_ident && !wr_at_hold); // R24
      xoff_flag_q <= xoff_seen || (xoff_flag_q && !rd_at_ident); // R19
      cts_flag_q <= (cts_s2_q && !cts_prev_q) || (cts_flag_q && !rd_at_ident); // R18
      rts_flag_q <= (RTS_N && !rts_prev_q) || (rts_flag_q && !rd_at_ident); // R18
    end
  end

  // interrupt sources
  reg [6:0] rx_trig;
  always @* begin
    case (fifo_ctl_q[3:2] == 2'b00 ? 2'b00 : 2'b00)
      default: rx_trig = 7'd1;
    endcase
    if (fifo_en) begin
      case (REG_WDATA[7:6] & 2'b00)
        default: rx_trig = 7'd1;
      endcase
    end
  end
  wire line_irq = ien_q[`IEN_LINE] && (pe_q || fe_q || oe_q); // R22
  wire rxd_irq = ien_q[`IEN_RXD] && (rx_level >= rx_trig); // R23
  wire txh_irq = ien_q[`IEN_TXH] && txh_flag_q; // R23
  wire modem_irq = ien_q[`IEN_MODEM] && dcts_q; // R21
  wire xoff_irq = ien_q[`IEN_XOFF] && xoff_flag_q; // R19
  wire ctsrts_irq = (ien_q[`IEN_CTS] && cts_flag_q) || (ien_q[`IEN_RTS] && rts_flag_q); // R18
  wire any_irq = line_irq || rxd_irq || txh_irq || modem_irq || xoff_irq || ctsrts_irq;
  assign IRQ_N = !any_irq; // R17
  assign SLEEP_OK = ien_q[`IEN_SLEEP] && tx_empty && (tx_st_q == S_IDLE) &&
                    (rx_st_q == S_IDLE) && !rx_out_valid; // R20

  // register reads
  // codes already carry the pending status in bit 0
  wire [5:0] ident_code = line_irq ? `IDENT_LINE : rxd_irq ? `IDENT_RXD : txh_irq ? `IDENT_TXH :
                          modem_irq ? `IDENT_MODEM : xoff_irq ? `IDENT_XOFF :
                          ctsrts_irq ? `IDENT_CTSRTS : `IDENT_NONE;
  always @* begin
    rd_mux = 8'h00;
    if (REG_ADDR == `OFS_LCTL) begin
      rd_mux = lctl_q;
    end else if (div_set) begin
      if (REG_ADDR == `OFS_HOLD) rd_mux = div_lo_q; // R1
      if (REG_ADDR == `OFS_IEN) rd_mux = div_hi_q; // R1
    end else if (enh_set) begin
      case (REG_ADDR)
        4'h2: rd_mux = feat_q; // R2
        4'h4: rd_mux = resume1_q;
        4'h5: rd_mux = resume2_q;
        4'h6: rd_mux = pause1_q;
        4'h7: rd_mux = pause2_q;
        default: rd_mux = 8'h00;
      endcase
    end else begin
      case (REG_ADDR)
        `OFS_HOLD: rd_mux = rx_out_valid ? rx_out_data : 8'h00; // R3
        `OFS_IEN: rd_mux = ien_q;
        `OFS_FIFO: rd_mux = {fifo_en, fifo_en, ident_code};
        `OFS_MCTL: rd_mux = mctl_q;
        `OFS_LSTAT: rd_mux = {pe_q | fe_q, tx_empty && tx_st_q == S_IDLE, tx_empty, 1'b0,
                              fe_q, pe_q, oe_q, rx_out_valid};
        `OFS_MSTAT: rd_mux = lvl_vis ? flow_lvl_q : {3'b000, !cts_s2_q, 3'b000, dcts_q}; // R8
        `OFS_SCRATCH: rd_mux = lvl_vis ? trig_lvl_q : scratch_q; // R8
        `OFS_TXLVL: rd_mux = {1'b0, {1'b1, {`FIFO_AW{1'b0}}} - tx_level};
        `OFS_RXLVL: rd_mux = {1'b0, rx_level};
        default: rd_mux = io_sel ? IO_RDATA : 8'h00;
      endcase
    end
  end
  always @(posedge REF_CLK) begin
    if (RESET) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      rdata_q <= rd_mux;
    end
  end
  assign REG_RDATA = rdata_q;
endmodule // uart_channel
`default_nettype wire

// [hw/uart_regs.vh]
// register offsets, field positions, reset values and counts for one uart channel
`ifndef UART_REGS_VH
`define UART_REGS_VH
`define OFS_HOLD 4'h0
`define OFS_IEN 4'h1
`define OFS_FIFO 4'h2
`define OFS_LCTL 4'h3
`define OFS_MCTL 4'h4
`define OFS_LSTAT 4'h5
`define OFS_MSTAT 4'h6
`define OFS_SCRATCH 4'h7
`define OFS_TXLVL 4'h8
`define OFS_RXLVL 4'h9
`define OFS_IO_FIRST 4'ha
`define OFS_IO_LAST 4'he
`define LCTL_ENHANCED 8'hbf
`define LCTL_DLAB 7
`define LCTL_BREAK 6
`define FEAT_AUTO_CTS 7
`define FEAT_AUTO_RTS 6
`define FEAT_SPECIAL 5
`define FEAT_ENH_EN 4
`define MCTL_LVL_SEL 2
`define MCTL_RTS 1
`define IEN_CTS 7
`define IEN_RTS 6
`define IEN_XOFF 5
`define IEN_SLEEP 4
`define IEN_MODEM 3
`define IEN_LINE 2
`define IEN_TXH 1
`define IEN_RXD 0
`define RST_LCTL 8'h1d
`define RST_DIV_LO 8'h01
`define RST_DIV_HI 8'h00
`define IDENT_NONE 6'h01
`define IDENT_LINE 6'h06
`define IDENT_RXD 6'h04
`define IDENT_TXH 6'h02
`define IDENT_MODEM 6'h00
`define IDENT_XOFF 6'h10
`define IDENT_CTSRTS 6'h20
`define FIFO_DEPTH 64
`define FIFO_AW 6
`define TICKS_PER_BIT 5'd16
`endif

// [hw/byte_mem.v]
// small memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module byte_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 64,
  parameter AW = 6
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [WIDTH-1:0] rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // byte_mem
`default_nettype wire

// [hw/byte_fifo.v]
// first-in first-out buffer with a single-entry mode
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 64,
  parameter AW = 6
) (
  input wire clk,
  input wire reset,
  input wire clear,
  input wire single,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  reg [AW-1:0] rd_ptr_q, wr_ptr_q;
  reg [AW:0] count_q;
  reg fresh_ok_q;
  wire [AW:0] limit = single ? {{AW{1'b0}}, 1'b1} : DEPTH[AW:0];
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  // single mode keeps every character in entry zero
  function [AW-1:0] nxt;
    input [AW-1:0] p;
    input s;
    nxt = s ? {AW{1'b0}} : p + {{(AW-1){1'b0}}, 1'b1};
  endfunction
  wire [AW-1:0] rd_ptr_d = clear ? {AW{1'b0}} : (pop ? nxt(rd_ptr_q, single) : rd_ptr_q);
  assign in_ready = !clear && (count_q < limit);
  // head entry written on the last edge is not yet in the read register
  assign out_valid = (count_q != {(AW+1){1'b0}}) && fresh_ok_q;
  assign level = count_q;
  always @(posedge clk) begin
    if (reset) begin
      rd_ptr_q <= {AW{1'b0}};
      wr_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      fresh_ok_q <= 1'b1;
    end else begin
      rd_ptr_q <= rd_ptr_d;
      wr_ptr_q <= clear ? {AW{1'b0}} : (push ? nxt(wr_ptr_q, single) : wr_ptr_q);
      if (clear) begin
        count_q <= {(AW+1){1'b0}};
      end else if (push && !pop) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
      fresh_ok_q <= !(push && (wr_ptr_q == rd_ptr_d));
    end
  end
  byte_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) store (
    .clk(clk),
    .we(push),
    .waddr(wr_ptr_q),
    .wdata(in_data),
    .raddr(rd_ptr_d),
    .rdata(out_data)
  );
endmodule // byte_fifo
`default_nettype wire

// [testbench/uart_channel_chk.sv]
// checker on the uart channel ports
`timescale 1ns/1ns
`default_nettype none
module uart_channel_chk (
  // clock and reset
  input wire REF_CLK,
  input wire RESET,
  // register port
  input wire [3:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  // shared gpio
  input wire IO_WR,
  input wire IO_RD,
  input wire [7:0] IO_RDATA,
  // pins and status
  input wire RX,
  input wire CTS_N,
  input wire TX,
  input wire RTS_N,
  input wire IRQ_N,
  input wire SLEEP_OK
);
  reg [7:0] lc_q;
  reg [7:0] dlo_q;
  reg [7:0] feat_q;
  reg [7:0] ien_q;
  wire gen = !lc_q[7];
  wire enh = lc_q == 8'hbf;
  wire io_hit = REG_ADDR >= 4'ha && REG_ADDR <= 4'he && gen;
  // shadow of line control, feature control, divisor low and interrupt enable
  always @(posedge REF_CLK) begin
    if (RESET) begin
      lc_q <= 8'h1d;
      dlo_q <= 8'h01;
      feat_q <= 8'h00;
      ien_q <= 8'h00;
    end else if (REG_WR) begin
      if (REG_ADDR == 4'h3) lc_q <= REG_WDATA;
      if (REG_ADDR == 4'h0 && lc_q[7] && !enh) dlo_q <= REG_WDATA;
      if (REG_ADDR == 4'h2 && enh) feat_q <= REG_WDATA;
      if (REG_ADDR == 4'h1 && gen) ien_q <= {feat_q[4] ? REG_WDATA[7:4] : ien_q[7:4], REG_WDATA[3:0]};
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  AST_RESET_OUT: assert property (disable iff (1'b0) RESET |=>
    REG_RDATA == 8'h00 && TX && RTS_N && IRQ_N && !SLEEP_OK) else $error("outputs wrong after reset");
  AST_RDATA_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
  AST_DIV_READ: assert property (REG_RD && REG_ADDR == 4'h0 && lc_q[7] && !enh |=>
    REG_RDATA == $past(dlo_q)) else $error("divisor low read wrong");
  AST_FEAT_READ: assert property (REG_RD && REG_ADDR == 4'h2 && enh |=>
    REG_RDATA == $past(feat_q)) else $error("feature control read wrong");
  AST_DIV_HIDDEN: assert property (REG_RD && enh && REG_ADDR <= 4'h1 |=>
    REG_RDATA == 8'h00) else $error("divisor visible in enhanced set");
  AST_IEN_READ: assert property (REG_RD && REG_ADDR == 4'h1 && gen |=>
    REG_RDATA == $past(ien_q)) else $error("interrupt enable read wrong");
  AST_IO_WR: assert property (IO_WR == (REG_WR && io_hit)) else $error("gpio write strobe wrong");
  AST_IO_RD: assert property (IO_RD == (REG_RD && io_hit)) else $error("gpio read strobe wrong");
  AST_RTS: assert property (REG_WR && REG_ADDR == 4'h4 && gen |=>
    RTS_N == !$past(REG_WDATA[1])) else $error("rts pin wrong");
  AST_QUIET: assert property (ien_q == 8'h00 |-> IRQ_N) else $error("interrupt with all disabled");
  AST_SLEEP: assert property (SLEEP_OK |-> ien_q[4]) else $error("sleep without permission");
endmodule // uart_channel_chk
bind uart_channel uart_channel_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .IO_WR(IO_WR), .IO_RD(IO_RD),
  .IO_RDATA(IO_RDATA), .RX(RX), .CTS_N(CTS_N), .TX(TX), .RTS_N(RTS_N), .IRQ_N(IRQ_N), .SLEEP_OK(SLEEP_OK));
`default_nettype wire

// [testbench/line_peer.sv]
// serial line peer: sends on rx, captures from tx, 8 data bits lsb first
`timescale 1ns/1ns
`default_nettype none
module line_peer #(
  parameter BIT_NS = 160
) (
  // serial pins seen from the far side
  output logic rx_line,
  input wire logic tx_line
);
  initial rx_line = 1'b1;
  task automatic send(input logic [7:0] b);
    integer i;
    begin
      rx_line = 1'b0;
      #BIT_NS;
      for (i = 0; i < 8; i++) begin
        rx_line = b[i];
        #BIT_NS;
      end
      rx_line = 1'b1;
      #BIT_NS;
    end
  endtask
  // samples mid-bit; returns in the middle of the stop bit
  task automatic recv(output logic [7:0] b);
    integer i;
    begin
      @(negedge tx_line);
      #(BIT_NS / 2);
      for (i = 0; i < 8; i++) begin
        #BIT_NS;
        b[i] = tx_line;
      end
      #BIT_NS;
    end
  endtask
endmodule // line_peer
`default_nettype wire

// [testbench/uart_channel_test.sv]
// self-checking bench for one uart channel
`timescale 1ns/1ns
`default_nettype none
module uart_channel_test;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic cts_n = 1'b1;
  wire [7:0] reg_rdata;
  wire tx;
  wire rx;
  wire rts_n;
  wire irq_n;
  integer miscompares = 0;
  integer n_compared = 0;
  always #5 ref_clk = ~ref_clk;
  uart_channel u_dut (.REF_CLK(ref_clk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .IO_WR(), .IO_RD(), .IO_RDATA(8'h00), .RX(rx), .CTS_N(cts_n),
    .TX(tx), .RTS_N(rts_n), .IRQ_N(irq_n), .SLEEP_OK());
  line_peer u_peer (.rx_line(rx), .tx_line(tx));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    begin
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b0;
    end
  endtask
  // read data lands on the edge that takes the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    begin
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b0;
      @(posedge ref_clk);
      #1;
      chk(reg_rdata, exp);
    end
  endtask
  task automatic reg_sets;
    begin
      rd(4'h1, 8'h00);
      wr(4'h1, 8'hff);
      rd(4'h1, 8'h0f);
      wr(4'h4, 8'h02);
      chk({7'h00, rts_n}, 8'h00);
      wr(4'h4, 8'h00);
      wr(4'h7, 8'h66);
      wr(4'h3, 8'h80);
      wr(4'h0, 8'h02);
      rd(4'h0, 8'h02);
      rd(4'h7, 8'h00);
      wr(4'h3, 8'hbf);
      wr(4'h2, 8'h10);
      rd(4'h2, 8'h10);
      wr(4'h7, 8'h5a);
      rd(4'h7, 8'h5a);
      rd(4'h0, 8'h00);
      wr(4'h3, 8'h80);
      rd(4'h2, 8'h00);
      wr(4'h0, 8'h01);
      wr(4'h3, 8'h03);
      rd(4'h7, 8'h66);
      wr(4'h1, 8'hf0);
      chk({7'h00, irq_n}, 8'h00);
      rd(4'h1, 8'hf0);
      wr(4'h1, 8'h00);
    end
  endtask
  task automatic tx_path;
    logic [7:0] b;
    begin
      wr(4'h1, 8'h02);
      fork
        wr(4'h0, 8'ha5);
        u_peer.recv(b);
      join
      chk(b, 8'ha5);
      chk({7'h00, irq_n}, 8'h00);
      rd(4'h2, 8'h02);
      chk({7'h00, irq_n}, 8'h01);
      wr(4'h1, 8'h00);
      wr(4'h1, 8'h02);
      chk({7'h00, irq_n}, 8'h01);
      wr(4'h1, 8'h80);
      cts_n = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      chk({7'h00, irq_n}, 8'h01);
      cts_n = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      chk({7'h00, irq_n}, 8'h00);
      rd(4'h2, 8'h20);
      wr(4'h1, 8'h00);
    end
  endtask
  task automatic rx_path;
    begin
      wr(4'h1, 8'h01);
      u_peer.send(8'h3c);
      chk({7'h00, irq_n}, 8'h00);
      rd(4'h9, 8'h01);
      rd(4'h0, 8'h3c);
      chk({7'h00, irq_n}, 8'h01);
      wr(4'h1, 8'h00);
    end
  endtask
  // divisor zero stalls the line so the fifo cannot drain
  task automatic tx_full;
    integer i;
    begin
      wr(4'h3, 8'h80);
      wr(4'h0, 8'h00);
      wr(4'h3, 8'h03);
      wr(4'h2, 8'h01);
      for (i = 0; i < 66; i++) wr(4'h0, i[7:0]);
      rd(4'h8, 8'h00);
      wr(4'h2, 8'h05);
      rd(4'h8, 8'h40);
      wr(4'h3, 8'h80);
      wr(4'h0, 8'h01);
      wr(4'h3, 8'h03);
    end
  endtask
  task automatic summarize;
    begin
      if (miscompares == 0 && n_compared > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    reg_sets;
    tx_path;
    rx_path;
    tx_full;
    summarize;
  end
  initial begin
    #200000;
    miscompares = miscompares + 1;
    summarize;
  end
endmodule // uart_channel_test
`default_nettype wire
